/* logic/gp_pkg.sv */
// Constants for the two-port general-purpose I/O block.
// Assumes an APB3 slave with 32-bit data and a 100 MHz system clock.
package gp_pkg;

	// ----------------------------------------------------------------
	// Port widths
	// ----------------------------------------------------------------
	localparam int PA_W = 16;
	localparam int PB_W = 24;
	localparam int IRQ_W = 16;
	localparam int ADDR_W = 12;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_PA_DIR = 12'h000;
	localparam logic [11:0] OFF_PA_PIN = 12'h004;
	localparam logic [11:0] OFF_PA_OUT = 12'h008;
	localparam logic [11:0] OFF_PA_CLR = 12'h00C;
	localparam logic [11:0] OFF_PA_PU = 12'h010;
	localparam logic [11:0] OFF_PA_PD_DRV = 12'h014;
	localparam logic [11:0] OFF_PB_DIR = 12'h018;
	localparam logic [11:0] OFF_PB_PIN = 12'h01C;
	localparam logic [11:0] OFF_PB_OUT = 12'h020;
	localparam logic [11:0] OFF_PB_CLR = 12'h024;
	localparam logic [11:0] OFF_PB_PU = 12'h028;
	localparam logic [11:0] OFF_PB_PD_DRV = 12'h02C;
	localparam logic [11:0] OFF_PA_IRQ_EN = 12'h030;
	localparam logic [11:0] OFF_PB_IRQ_EN = 12'h034;
	localparam logic [11:0] OFF_PA_IRQ_TRIG = 12'h038;
	localparam logic [11:0] OFF_PB_IRQ_TRIG = 12'h03C;
	localparam logic [11:0] OFF_PA_IRQ_PEND = 12'h040;
	localparam logic [11:0] OFF_PB_IRQ_PEND = 12'h044;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_PA = 16'h0000;
	localparam logic [23:0] RST_PB = 24'h000000;
	localparam logic [15:0] RST_IRQ = 16'h0000;
	localparam logic [31:0] RST_RDATA = 32'h00000000;

	// ----------------------------------------------------------------
	// Field values
	// ----------------------------------------------------------------
	localparam logic DIR_OUT = 1'b1; // Direction bit value for an output.
	localparam logic TRIG_EDGE = 1'b1; // Trigger bit value for edge mode.
	localparam logic [2:0] SETTLE_CNT = 3'h5; // Edges after reset until filtered levels hold.

endpackage : gp_pkg

/* logic/gp_port.sv */
// Two general-purpose I/O ports (16 and 24 pins) with per-pin interrupts on pins 0 to 15 of each port.
// Assumes an APB3 master on i_clk, and pin pads that resolve the drive,
// pull and strength controls given here into the board-level wire.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps

// Behaviour
// [RULE_01] Port B has a per-pin trigger bit: 1 edge, 0 level, reset zero.
// [RULE_02] Per-pin pending flags per port; write 1 clears, write 0 keeps.
// [RULE_03] Port A uses 16 low bits, port B 24; upper bits read zero.
// [RULE_04] Direction bit 1 is output, 0 input; all pins reset as inputs.
// [RULE_05] Pin-level register returns each pin's present synchronised level.
// [RULE_06] For an output pin, the output bit sets the driven level.
// [RULE_07] For an input pin, the output bit selects interrupt polarity.
// [RULE_08] Writing 1 to the clear register zeroes that output bit; holds nothing.
// [RULE_09] Pull-up enable bit per pin, 1 on, reset zero.
// [RULE_10] For an input pin, pull-down/drive bit enables the pull-down.
// [RULE_11] For an output pin, pull-down/drive bit selects high or low drive.
// [RULE_12] Per-pin interrupt enable bit, reset zero.
// [RULE_13] Port A has a per-pin trigger bit: 1 edge, 0 level.
// [RULE_14] Flags set on selected edge or level of the synchronised input.
// [RULE_15] Each port requests an interrupt when a flag and its enable are set.
module gp_port (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [15:0] i_pa_pin,
	output logic [15:0] o_pa_out,
	output logic [15:0] o_pa_oe,
	output logic [15:0] o_pa_pullup,
	output logic [15:0] o_pa_pulldown,
	output logic [15:0] o_pa_drive_high,
	input wire logic [23:0] i_pb_pin,
	output logic [23:0] o_pb_out,
	output logic [23:0] o_pb_oe,
	output logic [23:0] o_pb_pullup,
	output logic [23:0] o_pb_pulldown,
	output logic [23:0] o_pb_drive_high,
	output logic o_pa_irq,
	output logic o_pb_irq
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Interrupt events for one port: only pins set as inputs can fire.
	// Polarity comes from the output bit while the pin is an input.
	function automatic logic [15:0] gp_events(input logic [15:0] dir, input logic [15:0] pol,
		input logic [15:0] trig, input logic [15:0] lvl, input logic [15:0] prev);
		logic [15:0] rise, fall, edge_hit, level_hit;
		rise = lvl & ~prev;
		fall = ~lvl & prev;
		edge_hit = (pol & rise) | (~pol & fall); // RULE_07
		level_hit = ~(lvl ^ pol); // RULE_07
		gp_events = ~dir & ((trig & edge_hit) | (~trig & level_hit)); // RULE_14
	endfunction : gp_events

	// Next pending flags: a new event wins over a write-1 clear.
	function automatic logic [15:0] gp_pending(input logic [15:0] cur, input logic [15:0] clr,
		input logic [15:0] ev);
		gp_pending = (cur & ~clr) | ev; // RULE_02
	endfunction : gp_pending

	// Pass a filtered level only once the two later stages agree.
	function automatic logic [23:0] gp_filter(input logic [23:0] cur, input logic [23:0] s2,
		input logic [23:0] s3);
		gp_filter = (cur & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
	endfunction : gp_filter

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [15:0] pa_dir_q, pa_out_q, pa_pu_q, pa_pd_drv_q;
	logic [23:0] pb_dir_q, pb_out_q, pb_pu_q, pb_pd_drv_q;
	logic [15:0] pa_irq_en_q, pb_irq_en_q, pa_trig_q, pb_trig_q, pa_pend_q, pb_pend_q;

	// Pin synchronisers and filtered levels.
	logic [15:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_lvl_q, pa_prev_q;
	logic [23:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_lvl_q, pb_prev_q;
	logic [23:0] pa_filt;
	logic [2:0] warm_q;
	logic settled;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic setup;
	logic wr_en;
	logic [31:0] rdata_d;
	logic hit_d;
	logic [15:0] pa_ev;
	logic [15:0] pb_ev;
	logic [15:0] pa_clr_w1c;
	logic [15:0] pb_clr_w1c;

	// A write takes effect only at the access edge where pready is high.
	assign setup = i_psel & ~i_penable;
	assign wr_en = i_psel & i_penable & o_pready & i_pwrite;

	// Read mux; narrow registers sit in the low bits, the rest reads zero.
	always_comb begin
		rdata_d = gp_pkg::RST_RDATA;
		hit_d = 1'b1;
		unique case (i_paddr)
			gp_pkg::OFF_PA_DIR: rdata_d = {16'h0000, pa_dir_q}; // RULE_03
			gp_pkg::OFF_PA_PIN: rdata_d = {16'h0000, pa_lvl_q}; // RULE_05
			gp_pkg::OFF_PA_OUT: rdata_d = {16'h0000, pa_out_q};
			gp_pkg::OFF_PA_CLR: rdata_d = gp_pkg::RST_RDATA; // RULE_08
			gp_pkg::OFF_PA_PU: rdata_d = {16'h0000, pa_pu_q};
			gp_pkg::OFF_PA_PD_DRV: rdata_d = {16'h0000, pa_pd_drv_q};
			gp_pkg::OFF_PB_DIR: rdata_d = {8'h00, pb_dir_q}; // RULE_03
			gp_pkg::OFF_PB_PIN: rdata_d = {8'h00, pb_lvl_q}; // RULE_05
			gp_pkg::OFF_PB_OUT: rdata_d = {8'h00, pb_out_q};
			gp_pkg::OFF_PB_CLR: rdata_d = gp_pkg::RST_RDATA; // RULE_08
			gp_pkg::OFF_PB_PU: rdata_d = {8'h00, pb_pu_q};
			gp_pkg::OFF_PB_PD_DRV: rdata_d = {8'h00, pb_pd_drv_q};
			gp_pkg::OFF_PA_IRQ_EN: rdata_d = {16'h0000, pa_irq_en_q};
			gp_pkg::OFF_PB_IRQ_EN: rdata_d = {16'h0000, pb_irq_en_q};
			gp_pkg::OFF_PA_IRQ_TRIG: rdata_d = {16'h0000, pa_trig_q};
			gp_pkg::OFF_PB_IRQ_TRIG: rdata_d = {16'h0000, pb_trig_q};
			gp_pkg::OFF_PA_IRQ_PEND: rdata_d = {16'h0000, pa_pend_q};
			gp_pkg::OFF_PB_IRQ_PEND: rdata_d = {16'h0000, pb_pend_q};
			default: hit_d = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------

	// Read data is caught in the setup cycle, so pready rises with penable
	// and every transfer completes without a wait state.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= gp_pkg::RST_RDATA;
		end else if (setup) begin
			o_pready <= 1'b1;
			o_pslverr <= ~hit_d;
			o_prdata <= (i_pwrite || !hit_d) ? gp_pkg::RST_RDATA : rdata_d;
		end else begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Port A configuration registers
	// ----------------------------------------------------------------

	// Direction, pulls and drive strength, all plain read/write.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pa_dir_q <= gp_pkg::RST_PA; // RULE_04
			pa_pu_q <= gp_pkg::RST_PA; // RULE_09
			pa_pd_drv_q <= gp_pkg::RST_PA;
		end else if (wr_en) begin
			if (i_paddr == gp_pkg::OFF_PA_DIR) begin
				pa_dir_q <= i_pwdata[15:0]; // RULE_04
			end
			if (i_paddr == gp_pkg::OFF_PA_PU) begin
				pa_pu_q <= i_pwdata[15:0]; // RULE_09
			end
			if (i_paddr == gp_pkg::OFF_PA_PD_DRV) begin
				pa_pd_drv_q <= i_pwdata[15:0];
			end
		end
	end

	// Output data; the clear register only zeroes bits and stores nothing.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pa_out_q <= gp_pkg::RST_PA;
		end else if (wr_en && i_paddr == gp_pkg::OFF_PA_OUT) begin
			pa_out_q <= i_pwdata[15:0];
		end else if (wr_en && i_paddr == gp_pkg::OFF_PA_CLR) begin
			pa_out_q <= pa_out_q & ~i_pwdata[15:0]; // RULE_08
		end
	end

	// ----------------------------------------------------------------
	// Port B configuration registers
	// ----------------------------------------------------------------

	// Same layout as port A, eight pins wider.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pb_dir_q <= gp_pkg::RST_PB; // RULE_04
			pb_pu_q <= gp_pkg::RST_PB; // RULE_09
			pb_pd_drv_q <= gp_pkg::RST_PB;
		end else if (wr_en) begin
			if (i_paddr == gp_pkg::OFF_PB_DIR) begin
				pb_dir_q <= i_pwdata[23:0]; // RULE_04
			end
			if (i_paddr == gp_pkg::OFF_PB_PU) begin
				pb_pu_q <= i_pwdata[23:0]; // RULE_09
			end
			if (i_paddr == gp_pkg::OFF_PB_PD_DRV) begin
				pb_pd_drv_q <= i_pwdata[23:0];
			end
		end
	end

	// Port B output data and its write-1 clear.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pb_out_q <= gp_pkg::RST_PB;
		end else if (wr_en && i_paddr == gp_pkg::OFF_PB_OUT) begin
			pb_out_q <= i_pwdata[23:0];
		end else if (wr_en && i_paddr == gp_pkg::OFF_PB_CLR) begin
			pb_out_q <= pb_out_q & ~i_pwdata[23:0]; // RULE_08
		end
	end

	// ----------------------------------------------------------------
	// Interrupt configuration
	// ----------------------------------------------------------------

	// Only pins 0 to 15 of port B can interrupt; its upper pins have no bits.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pa_irq_en_q <= gp_pkg::RST_IRQ; // RULE_12
			pb_irq_en_q <= gp_pkg::RST_IRQ; // RULE_12
			pa_trig_q <= gp_pkg::RST_IRQ; // RULE_13
			pb_trig_q <= gp_pkg::RST_IRQ; // RULE_01
		end else if (wr_en) begin
			if (i_paddr == gp_pkg::OFF_PA_IRQ_EN) begin
				pa_irq_en_q <= i_pwdata[15:0]; // RULE_12
			end
			if (i_paddr == gp_pkg::OFF_PB_IRQ_EN) begin
				pb_irq_en_q <= i_pwdata[15:0]; // RULE_12
			end
			if (i_paddr == gp_pkg::OFF_PA_IRQ_TRIG) begin
				pa_trig_q <= i_pwdata[15:0]; // RULE_13
			end
			if (i_paddr == gp_pkg::OFF_PB_IRQ_TRIG) begin
				pb_trig_q <= i_pwdata[15:0]; // RULE_01
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------

	// Port A reuses the 24-bit filter with its upper bits held at zero.
	assign pa_filt = gp_filter({8'h00, pa_lvl_q}, {8'h00, pa_s2_q}, {8'h00, pa_s3_q});

	// Three stages; the filtered level moves only once stages two and
	// three agree, which also rejects a single-cycle glitch.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pa_s1_q <= gp_pkg::RST_PA;
			pa_s2_q <= gp_pkg::RST_PA;
			pa_s3_q <= gp_pkg::RST_PA;
			pa_lvl_q <= gp_pkg::RST_PA;
			pa_prev_q <= gp_pkg::RST_PA;
			pb_s1_q <= gp_pkg::RST_PB;
			pb_s2_q <= gp_pkg::RST_PB;
			pb_s3_q <= gp_pkg::RST_PB;
			pb_lvl_q <= gp_pkg::RST_PB;
			pb_prev_q <= gp_pkg::RST_PB;
		end else begin
			pa_s1_q <= i_pa_pin;
			pa_s2_q <= pa_s1_q;
			pa_s3_q <= pa_s2_q;
			pa_lvl_q <= pa_filt[15:0]; // RULE_14
			pa_prev_q <= pa_lvl_q;
			pb_s1_q <= i_pb_pin;
			pb_s2_q <= pb_s1_q;
			pb_s3_q <= pb_s2_q;
			pb_lvl_q <= gp_filter(pb_lvl_q, pb_s2_q, pb_s3_q); // RULE_14
			pb_prev_q <= pb_lvl_q;
		end
	end

	// ----------------------------------------------------------------
	// Pending flags
	// ----------------------------------------------------------------

	// Events are computed from filtered levels only, never from stage one.
	assign pa_ev = gp_events(pa_dir_q, pa_out_q, pa_trig_q, pa_lvl_q, pa_prev_q) &
		{16{settled}};
	assign pb_ev = gp_events(pb_dir_q[15:0], pb_out_q[15:0], pb_trig_q, pb_lvl_q[15:0],
		pb_prev_q[15:0]) & {16{settled}};
	assign pa_clr_w1c = (wr_en && i_paddr == gp_pkg::OFF_PA_IRQ_PEND) ? i_pwdata[15:0] :
		gp_pkg::RST_IRQ;
	assign pb_clr_w1c = (wr_en && i_paddr == gp_pkg::OFF_PB_IRQ_PEND) ? i_pwdata[15:0] :
		gp_pkg::RST_IRQ;

	// Detection waits until the pins have refilled the synchronisers, so the
	// reset value of the filter never reads as a false edge or level.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			warm_q <= 3'h0;
		end else if (!settled) begin
			warm_q <= warm_q + 3'h1;
		end
	end
	assign settled = (warm_q == gp_pkg::SETTLE_CNT); // RULE_14

	// Flags collect events whether or not the pin is enabled, so software
	// can poll a masked pin; a level source re-sets its flag after a clear.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pa_pend_q <= gp_pkg::RST_IRQ; // RULE_02
			pb_pend_q <= gp_pkg::RST_IRQ; // RULE_02
		end else begin
			pa_pend_q <= gp_pending(pa_pend_q, pa_clr_w1c, pa_ev); // RULE_02
			pb_pend_q <= gp_pending(pb_pend_q, pb_clr_w1c, pb_ev); // RULE_02
		end
	end

	// ----------------------------------------------------------------
	// Registered pin controls and interrupt requests
	// ----------------------------------------------------------------

	// The shared pull-down/drive bit is split by direction here, so a pad
	// never sees a pull-down on a pin that it is driving.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_pa_out <= gp_pkg::RST_PA;
			o_pa_oe <= gp_pkg::RST_PA;
			o_pa_pullup <= gp_pkg::RST_PA;
			o_pa_pulldown <= gp_pkg::RST_PA;
			o_pa_drive_high <= gp_pkg::RST_PA;
			o_pb_out <= gp_pkg::RST_PB;
			o_pb_oe <= gp_pkg::RST_PB;
			o_pb_pullup <= gp_pkg::RST_PB;
			o_pb_pulldown <= gp_pkg::RST_PB;
			o_pb_drive_high <= gp_pkg::RST_PB;
		end else begin
			o_pa_out <= pa_out_q & pa_dir_q; // RULE_06
			o_pa_oe <= pa_dir_q; // RULE_04
			o_pa_pullup <= pa_pu_q; // RULE_09
			o_pa_pulldown <= pa_pd_drv_q & ~pa_dir_q; // RULE_10
			o_pa_drive_high <= pa_pd_drv_q & pa_dir_q; // RULE_11
			o_pb_out <= pb_out_q & pb_dir_q; // RULE_06
			o_pb_oe <= pb_dir_q; // RULE_04
			o_pb_pullup <= pb_pu_q; // RULE_09
			o_pb_pulldown <= pb_pd_drv_q & ~pb_dir_q; // RULE_10
			o_pb_drive_high <= pb_pd_drv_q & pb_dir_q; // RULE_11
		end
	end

	// One request line per port, from the enabled pending flags.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_pa_irq <= 1'b0;
			o_pb_irq <= 1'b0;
		end else begin
			o_pa_irq <= |(pa_pend_q & pa_irq_en_q); // RULE_15
			o_pb_irq <= |(pb_pend_q & pb_irq_en_q); // RULE_15
		end
	end

endmodule : gp_port

/* sim/gp_pin_model.sv */
// Board-side model of the pins of one port.
// Assumes the pad controls come straight from the block's registered outputs.
`timescale 1ns/10ps
module gp_pin_model #(
	parameter int W = 16
) (
	input wire logic i_clk,
	input wire logic [W-1:0] i_out,
	input wire logic [W-1:0] i_oe,
	input wire logic [W-1:0] i_pu,
	input wire logic [W-1:0] i_pd,
	input wire logic [W-1:0] i_ext,
	input wire logic [W-1:0] i_ext_en,
	output logic [W-1:0] o_pin
);
	// ----------------------------------------------------------------
	// Wire resolution
	// ----------------------------------------------------------------
	initial o_pin = '0;
	// An unheld, unpulled wire toggles, so a stale level never reads as good.
	always @(posedge i_clk) begin
		for (int k = 0; k < W; k++) begin
			o_pin[k] <= i_oe[k] ? i_out[k] : i_ext_en[k] ? i_ext[k] :
				i_pu[k] ? 1'b1 : i_pd[k] ? 1'b0 : ~o_pin[k];
		end
	end
endmodule : gp_pin_model

/* sim/gp_checker.sv */
// Port-level assertions for the two-port I/O block.
// Assumes it is bound into every instance of gp_port.
`timescale 1ns/10ps
module gp_checker (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [15:0] o_pa_out,
	input wire logic [15:0] o_pa_oe,
	input wire logic [15:0] o_pa_pulldown,
	input wire logic [15:0] o_pa_drive_high,
	input wire logic o_pa_irq,
	input wire logic o_pb_irq
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// The bus never inserts wait states, and each answer lasts one cycle.
	ready_zero_wait_a: assert property (i_psel && !i_penable |=> o_pready)
		else $error("pready missing in access cycle");
	ready_one_cycle_a: assert property (o_pready |=> !o_pready)
		else $error("pready held too long");
	slverr_zero_data_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
		else $error("error response with data");
	narrow_upper_zero_a: assert property (o_pready && !i_pwrite &&
		!(i_paddr inside {[12'h018:12'h02C]}) |-> o_prdata[31:16] == 16'h0000)
		else $error("reserved upper bits set");
	wide_upper_zero_a: assert property (o_pready && !i_pwrite |-> o_prdata[31:24] == 8'h00)
		else $error("reserved top byte set");
	dir_write_oe_a: assert property (o_pready && i_penable && i_pwrite &&
		i_paddr == gp_pkg::OFF_PA_DIR |=> ##1 o_pa_oe == $past(i_pwdata[15:0], 2))
		else $error("drive enable does not follow direction");
	reset_inputs_a: assert property (disable iff (1'b0)
		!i_nrst |=> o_pa_oe == 16'h0000 && !o_pa_irq && !o_pb_irq)
		else $error("outputs not cleared by reset");
	out_needs_oe_a: assert property ((o_pa_out & ~o_pa_oe) == 16'h0000)
		else $error("level driven on an input pin");
	pulldown_input_a: assert property ((o_pa_pulldown & o_pa_oe) == 16'h0000)
		else $error("pull-down on an output pin");
	drive_output_a: assert property ((o_pa_drive_high & ~o_pa_oe) == 16'h0000)
		else $error("drive strength on an input pin");
	// Main scenarios seen.
	cov_write: cover property (o_pready && i_pwrite);
	cov_slverr: cover property (o_pslverr);
	cov_pa_irq: cover property ($rose(o_pa_irq));
	cov_pb_irq: cover property ($rose(o_pb_irq));
endmodule : gp_checker

bind gp_port gp_checker chk_u (.i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_pa_out, .o_pa_oe, .o_pa_pulldown,
	.o_pa_drive_high, .o_pa_irq, .o_pb_irq);

/* sim/tb_top.sv */
// Self-checking bench for the two-port I/O block.
// Assumes the pin models stand for the board and the checker is bound.
`timescale 1ns/10ps
module tb_top;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0;
	logic [31:0] o_prdata;
	logic o_pready, o_pslverr, o_pa_irq, o_pb_irq;
	logic [15:0] i_pa_pin, o_pa_out, o_pa_oe, o_pa_pullup, o_pa_pulldown, o_pa_drive_high;
	logic [23:0] i_pb_pin, o_pb_out, o_pb_oe, o_pb_pullup, o_pb_pulldown, o_pb_drive_high;
	logic [15:0] pa_ext = 16'hFFFF;
	logic [23:0] pb_ext = 24'hFFFFFF;
	logic [31:0] exp_q[$];
	logic last_err = 1'b0;
	logic [31:0] v[12];
	logic [11:0] rwa[12] = '{12'h000, 12'h008, 12'h010, 12'h014, 12'h018, 12'h020,
		12'h028, 12'h02C, 12'h030, 12'h034, 12'h038, 12'h03C};
	int seed = 32'h5092EE8B;
	int n_fail = 0;
	int checks_done = 0;

	always #5 i_clk = ~i_clk;

	gp_port dut_u (.i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
		.o_prdata, .o_pready, .o_pslverr, .i_pa_pin, .o_pa_out, .o_pa_oe, .o_pa_pullup,
		.o_pa_pulldown, .o_pa_drive_high, .i_pb_pin, .o_pb_out, .o_pb_oe, .o_pb_pullup,
		.o_pb_pulldown, .o_pb_drive_high, .o_pa_irq, .o_pb_irq);
	gp_pin_model #(.W(16)) pa_u (.i_clk, .i_out(o_pa_out), .i_oe(o_pa_oe),
		.i_pu(o_pa_pullup), .i_pd(o_pa_pulldown), .i_ext(pa_ext), .i_ext_en(16'hFFFF),
		.o_pin(i_pa_pin));
	gp_pin_model #(.W(24)) pb_u (.i_clk, .i_out(o_pb_out), .i_oe(o_pb_oe),
		.i_pu(o_pb_pullup), .i_pd(o_pb_pulldown), .i_ext(pb_ext), .i_ext_en(24'hFFFFFF),
		.o_pin(i_pb_pin));

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude

	// Holds the whole request until pready is seen at a rising edge; only the
	// watchdog ends a wait that never sees it.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (o_pready !== 1'b1);
		last_err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	function automatic logic [31:0] msk(input logic [11:0] a);
		return (a >= 12'h018 && a <= 12'h02C) ? 32'h00FFFFFF : 32'h0000FFFF;
	endfunction : msk

	// Read data is compared at the edge where the master takes it.
	always @(posedge i_clk) begin
		if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite && exp_q.size() > 0)
			check("prdata", exp_q.pop_front(), o_prdata);
	end

	// Generous span: the sequence needs only a few hundred cycles.
	initial begin
		#200000;
		n_fail++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge i_clk);
		i_nrst <= 1'b1;
		wr(12'h048, 32'hFFFFFFFF);
		check("pslverr", 32'h1, last_err);
		// Every register but the pin levels reads zero; 48h is unmapped.
		for (int a = 0; a <= 72; a += 4) if (a != 4 && a != 28) rd(12'(a), 32'h0);
		for (int i = 0; i < 12; i++) begin
			v[i] = $random(seed);
			wr(rwa[i], v[i]);
			rd(rwa[i], v[i] & msk(rwa[i]));
		end
		check("pa_oe", v[0][15:0], o_pa_oe);
		check("pa_out", v[1][15:0] & v[0][15:0], o_pa_out);
		check("pa_pu", v[2][15:0], o_pa_pullup);
		check("pa_pd", 16'(v[3][15:0] & ~v[0][15:0]), o_pa_pulldown);
		check("pa_drv", v[3][15:0] & v[0][15:0], o_pa_drive_high);
		check("pb_out", v[5][23:0] & v[4][23:0], o_pb_out);
		check("pb_pd", 24'(v[7][23:0] & ~v[4][23:0]), o_pb_pulldown);
		check("pb_oe", v[4][23:0], o_pb_oe);
		check("pb_pu", v[6][23:0], o_pb_pullup);
		check("pb_drv", v[7][23:0] & v[4][23:0], o_pb_drive_high);
		for (int i = 0; i < 12; i++) wr(rwa[i], 32'h0);
		wr(12'h008, 32'hFFFF);
		check("pslverr", 32'h0, last_err);
		wr(12'h00C, 32'h00F0);
		rd(12'h008, 32'hFF0F);
		rd(12'h00C, 32'h0);
		wr(12'h008, 32'h0);
		pa_ext <= 16'($random(seed));
		pb_ext <= 24'($random(seed));
		repeat (6) @(posedge i_clk);
		rd(12'h004, {16'h0, pa_ext});
		rd(12'h01C, {8'h0, pb_ext});
		pa_ext <= 16'hFFFF;
		pb_ext <= 24'hFFFFFF;
		repeat (6) @(posedge i_clk);
		// Port A pin 0: rising-edge interrupt, enabled.
		wr(12'h038, 32'h1);
		pa_ext[0] <= 1'b0;
		wr(12'h008, 32'h1);
		wr(12'h030, 32'h1);
		wr(12'h040, 32'hFFFF);
		wr(12'h044, 32'hFFFF);
		repeat (8) @(posedge i_clk);
		check("pa_irq", 32'h0, o_pa_irq);
		pa_ext[0] <= 1'b1;
		repeat (8) @(posedge i_clk);
		check("pa_irq", 32'h1, o_pa_irq);
		rd(12'h040, 32'h1);
		wr(12'h040, 32'h0);
		rd(12'h040, 32'h1);
		wr(12'h040, 32'h1);
		repeat (3) @(posedge i_clk);
		check("pa_irq", 32'h0, o_pa_irq);
		pa_ext[0] <= 1'b0;
		repeat (8) @(posedge i_clk);
		rd(12'h040, 32'h0);
		// Pin 1 stays low in low-level mode; its flag comes back after a clear.
		pa_ext[1] <= 1'b0;
		repeat (8) @(posedge i_clk);
		wr(12'h040, 32'h2);
		rd(12'h040, 32'h2);
		check("pa_irq", 32'h0, o_pa_irq);
		// Port B pin 3: falling-edge interrupt.
		wr(12'h03C, 32'h8);
		wr(12'h034, 32'h8);
		wr(12'h044, 32'hFFFF);
		pb_ext[3] <= 1'b0;
		repeat (8) @(posedge i_clk);
		check("pb_irq", 32'h1, o_pb_irq);
		rd(12'h044, 32'h8);
		repeat (4) @(posedge i_clk);
		conclude();
	end
endmodule : tb_top
